// *** rtl/ddrtp_blkram.sv ***
// local block ram holding one 2 KB block, 64-bit words
`timescale 1ns/1ps
module ddrtp_blkram (
  // clock
  input wire logic ref_clk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [ddrtp_pkg::RAM_AW-1:0] waddr,
  input wire logic [63:0] wdata,
  // read port, combinational so the write beat can be prefetched
  input wire logic [ddrtp_pkg::RAM_AW-1:0] raddr,
  output logic [63:0] rdata
);
  import ddrtp_pkg::*;
  logic [63:0] mem [RAM_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// *** rtl/ddrtp_pkg.sv ***
// constants and types shared by the throughput test sequencer
package ddrtp_pkg;
  localparam logic [7:0] HS_BYTE = 8'h63;
  localparam logic [7:0] ACK_BYTE = 8'h61;
  localparam logic [7:0] CMD_WR = 8'h25;
  localparam logic [7:0] CMD_RD = 8'h26;
  localparam logic [31:0] DDR_BASE = 32'h0000_0000;
  localparam logic [31:0] REGION_BYTES = 32'h0000_4000;
  localparam logic [17:0] ADDR_PAD = 18'h0;
  localparam logic [6:0] BURST_OFS = 7'h0;
  localparam logic [3:0] AXI_LEN = 4'hf;
  localparam logic [2:0] AXI_SIZE = 3'h3;
  localparam logic [1:0] AXI_INCR = 2'h1;
  localparam logic [7:0] STRB_ALL = 8'hff;
  localparam logic [2:0] LAST_BLK = 3'h7;
  localparam logic [3:0] LAST_BURST = 4'hf;
  localparam logic [3:0] LAST_BEAT = 4'hf;
  localparam logic [3:0] LAST_REP = 4'hf;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam int RAM_AW = 8;
  localparam int RAM_DEPTH = 256;

  typedef enum logic [8:0] {
    S_HS  = 9'h001,
    S_ACK = 9'h002,
    S_CMD = 9'h004,
    S_AW  = 9'h008,
    S_W   = 9'h010,
    S_B   = 9'h020,
    S_AR  = 9'h040,
    S_R   = 9'h080,
    S_REP = 9'h100
  } ddrtp_state_e;
endpackage

// *** rtl/ddrtp_sequencer.sv ***
// command interpreter and axi master for the ddr throughput test
// Overview of operation
// - wait for handshake 0x63 after reset
// - answer 0x61, then await write command
// - write command starts axi write sequence
// - after write, send throughput counts out
// - write copies 2 KB ram block to ddr
// - write block repeated eight times
// - writes land in rows 0-1, banks 0-3
// - counts stored at addresses from zero upward
// - after write, handshake again, await read
// - read command starts axi read sequence
// - after read, send throughput counts out
// - read copies 2 KB ddr block to ram
// - read block repeated eight times
// - reads fetch rows 0-1, banks 0-3
// - write command byte is 00100101
// - read command byte is 00100110
`timescale 1ns/1ps
module ddrtp_sequencer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // uart byte receive
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  // uart byte transmit
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // axi write address
  output logic [31:0] awaddr,
  output logic [3:0] awlen,
  output logic [2:0] awsize,
  output logic [1:0] awburst,
  output logic awvalid,
  input wire logic awready,
  // axi write data and response
  output logic [63:0] wdata,
  output logic [7:0] wstrb,
  output logic wlast,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // axi read address and data
  output logic [31:0] araddr,
  output logic [3:0] arlen,
  output logic [2:0] arsize,
  output logic [1:0] arburst,
  output logic arvalid,
  input wire logic arready,
  input wire logic [63:0] rdata,
  input wire logic rlast,
  input wire logic rvalid,
  output logic rready
);
  import ddrtp_pkg::*;

  typedef struct packed {
    ddrtp_state_e st;
    logic rd_mode;
    logic expect_rd;
    logic [2:0] blk;
    logic [3:0] burst;
    logic [3:0] beat;
    logic [15:0] cyc;
    logic [7:0][15:0] cnt;
    logic [3:0] rep;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [31:0] awaddr;
    logic awvalid;
    logic [63:0] wdata;
    logic wlast;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } ddrtp_state_s;

  ddrtp_state_s q, d;
  logic [63:0] ram_rdata;
  logic [RAM_AW-1:0] ram_raddr;
  logic ram_we;
  logic burst_done;
  logic [15:0] cyc_inc;

  // one 2 KB row per bank, so block n sits at bank n[1:0], row n[2]
  function automatic logic [31:0] blk_addr(input logic [2:0] b,
                                           input logic [3:0] u);
    return DDR_BASE | {ADDR_PAD, b, u, BURST_OFS};
  endfunction

  assign ram_raddr = (q.st == S_AW) ? {q.burst, 4'h0} :
                     {q.burst, q.beat + 4'h1};
  assign ram_we = q.rready && rvalid;

  ddrtp_blkram ddrtp_blkram_inst (
    .ref_clk(ref_clk),
    .ce(ce),
    .we(ram_we),
    .waddr({q.burst, q.beat}),
    .wdata(rdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  // saturate rather than wrap so a stalled controller reads as slow
  assign cyc_inc = (q.cyc == CNT_MAX) ? q.cyc : q.cyc + CNT_ONE;

  always_comb begin
    d = q;
    burst_done = 1'b0;
    if (q.st inside {S_AW, S_W, S_B, S_AR, S_R}) begin
      d.cyc = cyc_inc;
    end
    case (q.st)
      S_HS: begin
        if (rx_valid && rx_data == HS_BYTE) begin
          d.tx_data = ACK_BYTE;
          d.tx_valid = 1'b1;
          d.st = S_ACK;
        end
      end
      S_ACK: begin
        if (tx_ready) begin
          d.tx_valid = 1'b0;
          d.st = S_CMD;
        end
      end
      S_CMD: begin
        // other bytes are dropped and the wait goes on
        if (rx_valid && !q.expect_rd && rx_data == CMD_WR) begin
          d.rd_mode = 1'b0;
          d.awvalid = 1'b1;
          d.awaddr = blk_addr(3'h0, 4'h0);
          d.st = S_AW;
        end else if (rx_valid && q.expect_rd
                     && rx_data == CMD_RD) begin
          d.rd_mode = 1'b1;
          d.arvalid = 1'b1;
          d.araddr = blk_addr(3'h0, 4'h0);
          d.st = S_AR;
        end
        if (d.st != S_CMD) begin
          d.blk = 3'h0;
          d.burst = 4'h0;
          d.beat = 4'h0;
          d.cyc = 16'h0;
          d.cnt = '0;
        end
      end
      S_AW: begin
        if (awready) begin
          d.awvalid = 1'b0;
          d.wvalid = 1'b1;
          d.wdata = ram_rdata;
          d.wlast = 1'b0;
          d.beat = 4'h0;
          d.st = S_W;
        end
      end
      S_W: begin
        if (wready) begin
          if (q.wlast) begin
            d.wvalid = 1'b0;
            d.wlast = 1'b0;
            d.bready = 1'b1;
            d.st = S_B;
          end else begin
            d.beat = q.beat + 4'h1;
            d.wdata = ram_rdata;
            d.wlast = (d.beat == LAST_BEAT);
          end
        end
      end
      S_B: begin
        if (bvalid) begin
          d.bready = 1'b0;
          burst_done = 1'b1;
        end
      end
      S_AR: begin
        if (arready) begin
          d.arvalid = 1'b0;
          d.rready = 1'b1;
          d.beat = 4'h0;
          d.st = S_R;
        end
      end
      S_R: begin
        if (rvalid) begin
          d.beat = q.beat + 4'h1;
          if (rlast) begin
            d.rready = 1'b0;
            burst_done = 1'b1;
          end
        end
      end
      S_REP: begin
        if (!q.tx_valid) begin
          d.tx_data = q.rep[0] ? q.cnt[q.rep[3:1]][15:8] :
                      q.cnt[q.rep[3:1]][7:0];
          d.tx_valid = 1'b1;
        end else if (tx_ready) begin
          d.tx_valid = 1'b0;
          d.rep = q.rep + 4'h1;
          if (q.rep == LAST_REP) begin
            d.expect_rd = !q.expect_rd;
            d.st = S_HS;
          end
        end
      end
      default: begin
        d.st = S_HS;
      end
    endcase
    if (burst_done) begin
      if (q.burst == LAST_BURST) begin
        d.cnt[q.blk] = cyc_inc;
        d.cyc = 16'h0;
        d.burst = 4'h0;
        d.blk = q.blk + 3'h1;
      end else begin
        d.burst = q.burst + 4'h1;
      end
      if (q.burst == LAST_BURST && q.blk == LAST_BLK) begin
        d.rep = 4'h0;
        d.st = S_REP;
      end else if (q.rd_mode) begin
        d.arvalid = 1'b1;
        d.araddr = blk_addr(d.blk, d.burst);
        d.st = S_AR;
      end else begin
        d.awvalid = 1'b1;
        d.awaddr = blk_addr(d.blk, d.burst);
        d.st = S_AW;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '{st: S_HS, default: '0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign tx_data = q.tx_data;
  assign tx_valid = q.tx_valid;
  assign awaddr = q.awaddr;
  assign awlen = AXI_LEN;
  assign awsize = AXI_SIZE;
  assign awburst = AXI_INCR;
  assign awvalid = q.awvalid;
  assign wdata = q.wdata;
  assign wstrb = STRB_ALL;
  assign wlast = q.wlast;
  assign wvalid = q.wvalid;
  assign bready = q.bready;
  assign araddr = q.araddr;
  assign arlen = AXI_LEN;
  assign arsize = AXI_SIZE;
  assign arburst = AXI_INCR;
  assign arvalid = q.arvalid;
  assign rready = q.rready;

  sequence s_hs_seen;
    ce && q.st == S_HS && rx_valid && rx_data == HS_BYTE;
  endsequence
  sequence s_ack_out;
    tx_valid && tx_data == ACK_BYTE && q.st == S_ACK;
  endsequence

  property p_ack_after_hs;
    @(posedge ref_clk) disable iff (reset) s_hs_seen |=> s_ack_out;
  endproperty
  a_ack_after_hs: assert property (p_ack_after_hs) else $error("no ack");

  property p_hs_wait;
    @(posedge ref_clk) disable iff (reset)
      (q.st == S_HS && !(rx_valid && rx_data == HS_BYTE))
      |=> q.st == S_HS && !awvalid && !arvalid;
  endproperty
  a_hs_wait: assert property (p_hs_wait) else $error("left hs wait");

  property p_wr_start;
    @(posedge ref_clk) disable iff (reset)
      (ce && q.st == S_CMD && rx_valid && !q.expect_rd && rx_data == CMD_WR)
      |=> awvalid && awaddr == DDR_BASE && q.cyc == 16'h0 && q.cnt == '0;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("no write start");

  property p_rd_start;
    @(posedge ref_clk) disable iff (reset)
      (ce && q.st == S_CMD && rx_valid && q.expect_rd && rx_data == CMD_RD)
      |=> arvalid && araddr == DDR_BASE;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("no read start");

  property p_bad_cmd;
    @(posedge ref_clk) disable iff (reset)
      (q.st == S_CMD && !(ce && rx_valid
                         && rx_data == (q.expect_rd ? CMD_RD : CMD_WR)))
      |=> q.st == S_CMD;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad byte taken");

  property p_wlast_beat;
    @(posedge ref_clk) disable iff (reset)
      (wvalid && wlast) |-> q.beat == LAST_BEAT;
  endproperty
  a_wlast_beat: assert property (p_wlast_beat) else $error("short burst");

  property p_addr_range;
    @(posedge ref_clk) disable iff (reset)
      (awvalid || arvalid) |-> (awaddr < DDR_BASE + REGION_BYTES)
                               && (araddr < DDR_BASE + REGION_BYTES);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bad addr");

  property p_seq_end;
    @(posedge ref_clk) disable iff (reset)
      (ce && burst_done && q.burst == LAST_BURST && q.blk == LAST_BLK)
      |=> q.st == S_REP && q.rep == 4'h0 ##1 tx_valid;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("no report");

  property p_rep_done;
    @(posedge ref_clk) disable iff (reset)
      (ce && q.st == S_REP && tx_valid && tx_ready && q.rep == LAST_REP)
      |=> q.st == S_HS && $changed(q.expect_rd);
  endproperty
  a_rep_done: assert property (p_rep_done) else $error("bad report end");
endmodule

// *** testbench/ddrtp_axi_mem.sv ***
// axi slave standing in for the ddr controller, address-derived read data
`timescale 1ns/1ps
module ddrtp_axi_mem (
  // clock, reset and pacing
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  // write side
  input wire logic awvalid,
  output logic awready,
  input wire logic wvalid,
  input wire logic wlast,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read side
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [63:0] rdata,
  output logic rlast,
  output logic rvalid,
  input wire logic rready
);
  logic tog_q;
  logic act_q;
  logic [3:0] beat_q;
  logic [31:0] base_q;
  logic [31:0] ra;
  assign bresp = 2'h0;
  assign ra = base_q + {25'h0, beat_q, 3'h0};
  // swapped halves outside valid beats, so stale data never looks right
  assign rdata = rvalid ? {~ra, ra} : {ra, ~ra};
  assign rlast = rvalid && (beat_q == 4'hf);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tog_q <= 1'b0;
      awready <= 1'b0;
      arready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      act_q <= 1'b0;
      rvalid <= 1'b0;
      beat_q <= 4'h0;
      base_q <= 32'h0;
    end else begin
      tog_q <= ~tog_q;
      // slow mode stalls every other cycle on the aw, ar, w and r channels
      awready <= awvalid && !awready && (!slow || tog_q);
      arready <= arvalid && !arready && (!slow || tog_q);
      wready <= !slow || tog_q;
      if (wvalid && wready && wlast)
        bvalid <= 1'b1;
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (arvalid && arready) begin
        base_q <= araddr;
        beat_q <= 4'h0;
        act_q <= 1'b1;
      end
      if (rvalid && rready) begin
        beat_q <= beat_q + 4'h1;
        rvalid <= !slow && !rlast;
        if (rlast)
          act_q <= 1'b0;
      end else if (act_q)
        rvalid <= 1'b1;
    end
  end
endmodule

// *** testbench/test_ddrtp_sequencer.sv ***
// self-checking bench for the ddr throughput test sequencer
`timescale 1ns/1ps
module test_ddrtp_sequencer;
  import ddrtp_pkg::*;
  logic ref_clk, reset, ce, rx_valid, tx_valid, tx_ready, slow;
  logic [7:0] rx_data, tx_data, wstrb;
  logic [31:0] awaddr, araddr, x;
  logic [3:0] awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst, bresp;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rlast, rvalid, rready;
  logic [63:0] wdata, rdata;
  int err_total = 0;
  int checks = 0;
  int cyc = 0, aw_n = 0, ar_n = 0, w_n = 0, phase = 0;
  logic [15:0] cnt [8];
  logic [15:0] rd0;
  ddrtp_sequencer ddrtp_sequencer_inst (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .awaddr(awaddr), .awlen(awlen), .awsize(awsize),
    .awburst(awburst), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arlen(arlen), .arsize(arsize), .arburst(arburst),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rlast(rlast),
    .rvalid(rvalid), .rready(rready));
  ddrtp_axi_mem ddrtp_axi_mem_inst (
    .ref_clk(ref_clk), .reset(reset), .slow(slow), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wlast(wlast), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rlast(rlast),
    .rvalid(rvalid), .rready(rready));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk);
    rx_data = b;
    rx_valid = 1'b1;
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask
  task automatic take(input int lim, output logic [7:0] b);
    int i;
    i = 0;
    while (tx_valid !== 1'b1 && i < lim) begin
      @(negedge ref_clk);
      i++;
    end
    chk(tx_valid === 1'b1, "no tx byte");
    b = tx_data;
    tx_ready = 1'b1;
    @(negedge ref_clk);
    tx_ready = 1'b0;
    // one more cycle so a falling tx_valid is not taken twice
    @(negedge ref_clk);
  endtask
  task automatic hs();
    logic [7:0] b;
    send(HS_BYTE);
    take(6, b);
    chk(b === ACK_BYTE, "ack byte");
  endtask
  task automatic report();
    logic [7:0] lo, hi;
    for (int i = 0; i < 8; i++) begin
      take(30000, lo);
      take(8, hi);
      cnt[i] = {hi, lo};
      chk(cnt[i] >= 16'h0100 && cnt[i] !== CNT_MAX, "count range");
    end
  endtask
  // address order, burst shape and replayed data seen on the bus
  always @(posedge ref_clk) begin
    if (awvalid && awready) begin
      chk(awaddr === aw_n * 128 && awlen === AXI_LEN, "aw addr");
      chk(awsize === AXI_SIZE && awburst === AXI_INCR, "aw shape");
      aw_n++;
    end
    if (arvalid && arready) begin
      chk(araddr === ar_n * 128 && arsize === AXI_SIZE, "ar addr");
      chk(arlen === AXI_LEN && arburst === AXI_INCR, "ar shape");
      ar_n++;
    end
    if (phase == 2 && wvalid && wready) begin
      x = 32'(14336 + (w_n % 256) * 8);
      chk(wdata === {~x, x} && wlast === (w_n % 16 == 15), "wdata");
      w_n++;
    end
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end
  task automatic t_idle();
    ce = 1'b0;
    send(HS_BYTE);
    ce = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(tx_valid === 1'b0, "byte taken with ce low");
    send(CMD_WR);
    send(8'h00);
    repeat (4) @(negedge ref_clk);
    chk(tx_valid === 1'b0 && awvalid === 1'b0, "stray byte");
    $display("test idle done");
  endtask
  task automatic t_write1();
    hs();
    send(CMD_RD);
    repeat (4) @(negedge ref_clk);
    chk(arvalid === 1'b0 && awvalid === 1'b0, "wrong phase");
    send(CMD_WR);
    report();
    chk(aw_n == 128 && ar_n == 0 && wstrb === STRB_ALL, "writes");
    $display("test write done");
  endtask
  task automatic t_read();
    slow = 1'b1;
    hs();
    send(CMD_RD);
    report();
    chk(ar_n == 128 && aw_n == 128, "reads");
    rd0 = cnt[0];
    slow = 1'b0;
    $display("test read done");
  endtask
  task automatic t_write2();
    phase = 2;
    aw_n = 0;
    hs();
    send(CMD_WR);
    report();
    chk(w_n == 2048 && aw_n == 128, "beats");
    chk(cnt[0] < rd0, "counts not cleared");
    // an unstalled slave gives every block the same cycle count
    for (int i = 1; i < 8; i++)
      chk(cnt[i] === cnt[0], "uneven counts");
    $display("test replay done");
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    slow = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    t_idle();
    t_write1();
    t_read();
    t_write2();
    test_done();
  end
endmodule
